/* File: verilog/mdsr_pkg.sv */
// package: register map, field layout and shared types of the motor driver status bank
package mdsr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] MDSR_OFF_FAULT_STATUS  = 8'h00;
    localparam logic [7:0] MDSR_OFF_SPEED         = 8'h01;
    localparam logic [7:0] MDSR_OFF_RIPPLE_LOW    = 8'h02;
    localparam logic [7:0] MDSR_OFF_RIPPLE_HIGH   = 8'h03;
    localparam logic [7:0] MDSR_OFF_VOLTAGE       = 8'h04;
    localparam logic [7:0] MDSR_OFF_CURRENT       = 8'h05;
    localparam logic [7:0] MDSR_OFF_DUTY          = 8'h06;

    // ------------------------------------------------------------
    // fault status field positions
    // ------------------------------------------------------------
    localparam int MDSR_BIT_FAULT          = 7;
    localparam int MDSR_BIT_RSVD           = 6;
    localparam int MDSR_BIT_STALL          = 5;
    localparam int MDSR_BIT_OVERCURRENT    = 4;
    localparam int MDSR_BIT_OVERVOLTAGE    = 3;
    localparam int MDSR_BIT_THERMAL        = 2;
    localparam int MDSR_BIT_POWER_ON       = 1;
    localparam int MDSR_BIT_COUNT_REACHED  = 0;

    // ------------------------------------------------------------
    // reset values and code scales
    // ------------------------------------------------------------
    localparam logic [7:0]  MDSR_RST_BYTE      = 8'h00;
    localparam logic [15:0] MDSR_RST_COUNT     = 16'h0000;
    localparam logic [5:0]  MDSR_RST_DUTY      = 6'h00;
    localparam logic [7:0]  MDSR_CODE_RSVD     = 8'h00;
    localparam logic [7:0]  MDSR_VOLT_38V_CODE = 8'hE4;
    localparam logic [7:0]  MDSR_CURR_FS_CODE  = 8'hC0;
    localparam int          MDSR_CNT_W         = 16;
    localparam int          MDSR_DUTY_W        = 6;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic stall;
        logic overcurrent;
        logic overvoltage;
        logic thermal_shutdown;
    } mdsr_fault_ev_type;

    typedef struct packed {
        logic [7:0] estimated_speed;
        logic [7:0] motor_voltage_code;
        logic [7:0] motor_current_code;
        logic [5:0] duty_code;
    } mdsr_meas_type;

    typedef struct packed {
        logic       rd_en;
        logic [7:0] addr;
    } mdsr_rd_req_type;

endpackage

/* File: verilog/mdsr_ripple_count.sv */
// module: ripple counter with threshold compare and clear
`timescale 1ns/1ps
module mdsr_ripple_count
    import mdsr_pkg::*;
#(
    parameter int CNT_W = MDSR_CNT_W
) (
    input  wire logic             ref_clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             ripple_pulse_i,
    input  wire logic             clear_i,
    input  wire logic [CNT_W-1:0] threshold_i,
    output logic      [CNT_W-1:0] count_o,
    output logic                  exceeded_o
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } mdsr_rc_state_type;

    mdsr_rc_state_type state_q;
    mdsr_rc_state_type state_d;

    always_comb begin
        state_d = state_q;
        if (clear_i) begin
            state_d.cnt = CNT_W'(MDSR_RST_COUNT);
        end else if (ripple_pulse_i && state_q.cnt != {CNT_W{1'b1}}) begin
            state_d.cnt = state_q.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign count_o    = state_q.cnt;
    assign exceeded_o = state_q.cnt > threshold_i;

endmodule

/* File: verilog/mdsr_status_bank.sv */
// module: read-only status register bank of a brushed dc motor driver
`timescale 1ns/1ps
module mdsr_status_bank
    import mdsr_pkg::*;
#(
    parameter int CNT_W = MDSR_CNT_W
) (
    input  wire logic              ref_clk_i,
    input  wire logic              arst_n_i,
    // register read port
    input  wire mdsr_rd_req_type   rd_req_i,
    output logic      [7:0]        rd_data_o,
    output logic                   rd_valid_o,
    // command strobes from the control register bank
    input  wire logic              clear_count_command_i,
    input  wire logic              clear_fault_command_i,
    output logic                   clear_count_command_o,
    output logic                   clear_fault_command_o,
    // events and measurements from the analog and ripple logic
    input  wire mdsr_fault_ev_type fault_ev_i,
    input  wire logic              above_uv_threshold_i,
    input  wire logic              ripple_pulse_i,
    input  wire logic [CNT_W-1:0]  ripple_threshold_i,
    input  wire mdsr_meas_type     meas_i,
    // open-drain fault output pin
    output logic                   fault_output_pin_o,
    output logic                   fault_output_pin_oe_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic       stall;
        logic       overcurrent;
        logic       overvoltage;
        logic       thermal_shutdown;
        logic       power_on;
        logic       power_on_armed;
        logic       count_reached;
        logic       clear_count_command;
        logic       clear_fault_command;
        logic [7:0] rd_data;
        logic       rd_valid;
        mdsr_meas_type meas;
    } mdsr_bank_state_type;

    mdsr_bank_state_type state_q;
    mdsr_bank_state_type state_d;

    logic [CNT_W-1:0] ripple_counter_value;
    logic             ripple_exceeded;
    logic [7:0]       fault_byte;
    logic             any_fault;

    // ------------------------------------------------------------
    // ripple counter
    // ------------------------------------------------------------
    mdsr_ripple_count #(
        .CNT_W (CNT_W)
    ) u_ripple (
        .ref_clk_i      (ref_clk_i),
        .arst_n_i       (arst_n_i),
        .ripple_pulse_i (ripple_pulse_i),
        .clear_i        (state_q.clear_count_command),
        .threshold_i    (ripple_threshold_i),
        .count_o        (ripple_counter_value),
        .exceeded_o     (ripple_exceeded)
    );

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                            input logic [7:0] fbyte,
                                            input logic [CNT_W-1:0] cnt,
                                            input mdsr_meas_type m);
        logic [15:0] cnt16;
        cnt16 = 16'(cnt);
        case (addr)
            MDSR_OFF_FAULT_STATUS: read_mux = fbyte;
            MDSR_OFF_SPEED:        read_mux = m.estimated_speed;
            MDSR_OFF_RIPPLE_LOW:   read_mux = cnt16[7:0];
            MDSR_OFF_RIPPLE_HIGH:  read_mux = cnt16[15:8];
            MDSR_OFF_VOLTAGE:      read_mux = m.motor_voltage_code;
            MDSR_OFF_CURRENT:      read_mux = m.motor_current_code;
            MDSR_OFF_DUTY:         read_mux = {2'b00, m.duty_code};
            default:               read_mux = MDSR_CODE_RSVD;
        endcase
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        // commands follow their strobe inputs and return to zero one cycle after the strobe does
        state_d.clear_count_command = clear_count_command_i;
        state_d.clear_fault_command = clear_fault_command_i;
        state_d.meas    = meas_i;
        // clear first, then set, so an event in the clear cycle wins
        if (state_q.clear_fault_command) begin
            state_d.stall            = 1'b0;
            state_d.overcurrent      = 1'b0;
            state_d.overvoltage      = 1'b0;
            state_d.thermal_shutdown = 1'b0;
            if (state_q.power_on_armed) begin
                state_d.power_on = 1'b1;
            end
        end
        if (fault_ev_i.stall)            state_d.stall = 1'b1;
        if (fault_ev_i.overcurrent)      state_d.overcurrent = 1'b1;
        if (fault_ev_i.overvoltage)      state_d.overvoltage = 1'b1;
        if (fault_ev_i.thermal_shutdown) state_d.thermal_shutdown = 1'b1;
        // first rise above the threshold clears and arms the power-on flag
        if (above_uv_threshold_i && !state_q.power_on_armed) begin
            state_d.power_on       = 1'b0;
            state_d.power_on_armed = 1'b1;
        end
        if (state_q.clear_count_command) begin
            state_d.count_reached = 1'b0;
        end
        if (ripple_exceeded && !state_q.clear_count_command) begin
            state_d.count_reached = 1'b1;
        end
        // reads only sample; nothing is cleared by them
        state_d.rd_valid = rd_req_i.rd_en;
        if (rd_req_i.rd_en) begin
            state_d.rd_data = read_mux(rd_req_i.addr, fault_byte, ripple_counter_value, state_q.meas);
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // fault byte and pin
    // ------------------------------------------------------------
    assign any_fault = state_q.stall | state_q.overcurrent | state_q.overvoltage
                     | state_q.thermal_shutdown;

    always_comb begin
        fault_byte                        = MDSR_RST_BYTE;
        fault_byte[MDSR_BIT_FAULT]        = any_fault;
        fault_byte[MDSR_BIT_RSVD]         = 1'b0;
        fault_byte[MDSR_BIT_STALL]        = state_q.stall;
        fault_byte[MDSR_BIT_OVERCURRENT]  = state_q.overcurrent;
        fault_byte[MDSR_BIT_OVERVOLTAGE]  = state_q.overvoltage;
        fault_byte[MDSR_BIT_THERMAL]      = state_q.thermal_shutdown;
        fault_byte[MDSR_BIT_POWER_ON]     = state_q.power_on;
        fault_byte[MDSR_BIT_COUNT_REACHED] = state_q.count_reached;
    end

    assign fault_output_pin_o    = 1'b0;
    assign fault_output_pin_oe_o = any_fault;
    assign rd_data_o             = state_q.rd_data;
    assign rd_valid_o            = state_q.rd_valid;
    assign clear_count_command_o = state_q.clear_count_command;
    assign clear_fault_command_o = state_q.clear_fault_command;

endmodule

/* File: verif/mdsr_status_bank_asserts.sv */
// checker: timing relations on the status bank ports
`timescale 1ns/1ps
module mdsr_status_bank_chk
    import mdsr_pkg::*;
#(
    parameter int CNT_W = MDSR_CNT_W
) (
    input wire logic              ref_clk_i,
    input wire logic              arst_n_i,
    input wire mdsr_rd_req_type   rd_req_i,
    input wire logic [7:0]        rd_data_o,
    input wire logic              rd_valid_o,
    input wire logic              clear_count_command_i,
    input wire logic              clear_fault_command_i,
    input wire logic              clear_count_command_o,
    input wire logic              clear_fault_command_o,
    input wire mdsr_fault_ev_type fault_ev_i,
    input wire logic              above_uv_threshold_i,
    input wire logic              ripple_pulse_i,
    input wire logic [CNT_W-1:0]  ripple_threshold_i,
    input wire mdsr_meas_type     meas_i,
    input wire logic              fault_output_pin_o,
    input wire logic              fault_output_pin_oe_o
);
    default clocking dc @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    read_answer_a: assert property (1'b1 |=> rd_valid_o == $past(rd_req_i.rd_en))
        else $error("read answer not one cycle after request");
    unmapped_zero_a: assert property (rd_req_i.rd_en && rd_req_i.addr > 8'h06 |=> rd_data_o == 8'h00)
        else $error("unmapped offset returned nonzero");
    rsvd_bit_a: assert property (rd_req_i.rd_en && rd_req_i.addr == 8'h00 |=> !rd_data_o[6])
        else $error("reserved fault bit read as one");
    pin_low_a: assert property (!fault_output_pin_o)
        else $error("fault pin driven high");
    event_pin_a: assert property (fault_ev_i != 4'h0 |=> fault_output_pin_oe_o)
        else $error("fault event did not pull pin low");
    pin_hold_a: assert property (!clear_fault_command_o && fault_ev_i == 4'h0 |=> $stable(fault_output_pin_oe_o))
        else $error("fault pin changed without cause");
    flt_clear_a: assert property (clear_fault_command_o && fault_ev_i == 4'h0 |=> !fault_output_pin_oe_o)
        else $error("clear fault left pin pulled low");
    flt_echo_a: assert property (clear_fault_command_i |=> clear_fault_command_o)
        else $error("clear fault command bit not set");
    flt_self_a: assert property (!clear_fault_command_i |=> !clear_fault_command_o)
        else $error("clear fault command bit did not return");
    cnt_echo_a: assert property (clear_count_command_i |=> clear_count_command_o)
        else $error("clear count command bit not set");
    cnt_self_a: assert property (!clear_count_command_i |=> !clear_count_command_o)
        else $error("clear count command bit did not return");
endmodule

bind mdsr_status_bank mdsr_status_bank_chk #(.CNT_W(CNT_W)) u_mdsr_status_bank_chk (
    .ref_clk_i, .arst_n_i, .rd_req_i, .rd_data_o, .rd_valid_o, .clear_count_command_i,
    .clear_fault_command_i, .clear_count_command_o, .clear_fault_command_o, .fault_ev_i,
    .above_uv_threshold_i, .ripple_pulse_i, .ripple_threshold_i, .meas_i, .fault_output_pin_o,
    .fault_output_pin_oe_o
);

/* File: verif/mdsr_host.sv */
// host model: register reads and clear commands toward the status bank
`timescale 1ns/1ps
module mdsr_host
    import mdsr_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] rd_data_i,
    input  wire logic       rd_valid_i,
    output mdsr_rd_req_type rd_req_o,
    output logic            clear_count_o,
    output logic            clear_fault_o
);
    initial begin
        rd_req_o = '0;
        clear_count_o = 1'b0;
        clear_fault_o = 1'b0;
    end
    // reads only: reserved offsets are never modified
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge ref_clk_i);
        #1;
        rd_req_o = '{rd_en: 1'b1, addr: a};
        @(posedge ref_clk_i);
        #1;
        rd_req_o.rd_en = 1'b0;
        ok = rd_valid_i;
        d = rd_data_i;
    endtask
    // one-cycle command pulse, then one edge for the effect to land
    task automatic cmd(input logic fault);
        @(posedge ref_clk_i);
        #1;
        if (fault) clear_fault_o = 1'b1;
        else clear_count_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        clear_fault_o = 1'b0;
        clear_count_o = 1'b0;
        @(posedge ref_clk_i);
    endtask
endmodule

/* File: verif/tb_motor_driver_status_registers.sv */
// testbench: reads, commands and event stimulus for the status bank
`timescale 1ns/1ps
module tb_motor_driver_status_registers;
    import mdsr_pkg::*;
    logic              ref_clk_i, arst_n_i, above_uv, ripple, rd_valid, cc_i, cf_i, oe;
    logic [7:0]        rd_data;
    logic [15:0]       thr;
    mdsr_rd_req_type   req;
    mdsr_fault_ev_type ev;
    mdsr_meas_type     meas;
    int                n_errors = 0;
    int                checks_done = 0;

    mdsr_status_bank u_mdsr_status_bank (.ref_clk_i, .arst_n_i, .rd_req_i(req), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .clear_count_command_i(cc_i), .clear_fault_command_i(cf_i),
        .clear_count_command_o(), .clear_fault_command_o(), .fault_ev_i(ev), .above_uv_threshold_i(above_uv),
        .ripple_pulse_i(ripple), .ripple_threshold_i(thr), .meas_i(meas), .fault_output_pin_o(),
        .fault_output_pin_oe_o(oe));
    mdsr_host u_mdsr_host (.ref_clk_i, .rd_data_i(rd_data), .rd_valid_i(rd_valid), .rd_req_o(req),
        .clear_count_o(cc_i), .clear_fault_o(cf_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #200000;
        n_errors++;
        close_out();
    end
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: bit got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_mdsr_host.rd(a, d, ok);
        cmp1(ok, 1'b1);
        cmp8(d, exp);
    endtask
    task automatic ripples(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            #1;
            ripple = 1'b1;
            @(posedge ref_clk_i);
            #1;
            ripple = 1'b0;
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        arst_n_i = 1'b0;
        above_uv = 1'b0;
        ripple = 1'b0;
        ev = '0;
        thr = 16'h0003;
        meas = '0;
        repeat (10) @(posedge ref_clk_i);
        #1;
        arst_n_i = 1'b1;
        for (int a = 0; a < 7; a++) rd_chk(8'(a), MDSR_RST_BYTE);
        $display("test reset values done");
        meas = '{estimated_speed: 8'hA5, motor_voltage_code: MDSR_VOLT_38V_CODE,
                 motor_current_code: MDSR_CURR_FS_CODE, duty_code: 6'h3F};
        repeat (3) @(posedge ref_clk_i);
        rd_chk(MDSR_OFF_SPEED, 8'hA5);
        rd_chk(MDSR_OFF_VOLTAGE, 8'hE4);
        rd_chk(MDSR_OFF_CURRENT, 8'hC0);
        rd_chk(MDSR_OFF_DUTY, 8'h3F);
        rd_chk(8'h07, 8'h00);
        rd_chk(8'hFF, 8'h00);
        $display("test measurements done");
        ripples(3);
        rd_chk(MDSR_OFF_FAULT_STATUS, 8'h00);
        ripples(261);
        rd_chk(MDSR_OFF_RIPPLE_LOW, 8'h08);
        rd_chk(MDSR_OFF_RIPPLE_HIGH, 8'h01);
        rd_chk(MDSR_OFF_FAULT_STATUS, 8'h01);
        rd_chk(MDSR_OFF_RIPPLE_LOW, 8'h08);
        u_mdsr_host.cmd(1'b0);
        rd_chk(MDSR_OFF_FAULT_STATUS, 8'h00);
        rd_chk(MDSR_OFF_RIPPLE_LOW, 8'h00);
        rd_chk(MDSR_OFF_RIPPLE_HIGH, 8'h00);
        $display("test ripple counter done");
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk_i);
            #1;
            ev = 4'b0001 << i;
            @(posedge ref_clk_i);
            #1;
            ev = '0;
            rd_chk(MDSR_OFF_FAULT_STATUS, 8'h80 | (8'h04 << i));
            cmp1(oe, 1'b1);
            u_mdsr_host.cmd(1'b1);
            rd_chk(MDSR_OFF_FAULT_STATUS, 8'h00);
            cmp1(oe, 1'b0);
        end
        $display("test fault flags done");
        above_uv = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rd_chk(MDSR_OFF_FAULT_STATUS, 8'h00);
        u_mdsr_host.cmd(1'b1);
        rd_chk(MDSR_OFF_FAULT_STATUS, 8'h02);
        $display("test power on flag done");
        close_out();
    end
endmodule
